/* File: inc/sil_map.svh */
`ifndef SIL_MAP_SVH
`define SIL_MAP_SVH

// Register offsets (7-bit register address space)
`define SIL_OFS_MOM_SEL 7'h6F
`define SIL_OFS_MOM_STAT 7'h70
`define SIL_OFS_LATCHED 7'h71
`define SIL_OFS_IRQ_EN 7'h72
`define SIL_OFS_CTRL 7'h73
`define SIL_OFS_OUT_EN_1 7'h74
`define SIL_OFS_SYSREF_CFG 7'h75
`define SIL_OFS_OUT_EN_2 7'h76
`define SIL_OFS_SYSREF_CNT 7'h77
`define SIL_OFS_FORBIDDEN 7'h78

// Control register fields
`define SIL_CTRL_DIV_INIT 0
`define SIL_CTRL_REARM 1
`define SIL_CTRL_CAL 2
`define SIL_CTRL_RELEASE 3
`define SIL_CTRL_FORCE 4
`define SIL_CTRL_BYPASS 5
`define SIL_CTRL_LOL_MASK 6

// Sysref configuration fields
`define SIL_SRC_SEL 0
`define SIL_RUN_MODE 1

// Latched / enable field positions
`define SIL_EV_CLK0 0
`define SIL_EV_CLK1 1
`define SIL_EV_VCXO 2
`define SIL_EV_SYNTH 3
`define SIL_EV_HOLD 4
`define SIL_EV_REF 5
`define SIL_EV_W 6

// Reset values
`define SIL_RST_CTRL 8'h10
`define SIL_RST_OUT_EN 8'h00
`define SIL_RST_IRQ_EN 6'h00
`define SIL_RST_SYSREF_CFG 2'h0
`define SIL_RST_SYSREF_CNT 8'h01
`define SIL_RST_VCXO_BUF 1'b1

// Timing
`define SIL_CLK_PERIOD_NS 40
`define SIL_INIT_TIME_NS 640
`define SIL_INIT_CYCLES \
    ((`SIL_INIT_TIME_NS + `SIL_CLK_PERIOD_NS - 1) / `SIL_CLK_PERIOD_NS)

`endif

/* File: inc/sil_pkg.sv */
package sil_pkg;

    typedef logic [7:0] sil_byte_t;
    typedef logic [5:0] sil_event_t;

    typedef enum logic [2:0] {
        SIL_REL_IDLE = 3'b001,
        SIL_REL_WAIT_EDGE = 3'b010,
        SIL_REL_FIRE = 3'b100
    } sil_rel_e;

    // Reference input modes
    typedef enum logic [1:0] {
        SIL_MODE_MANUAL = 2'b00,
        SIL_MODE_SHORT_HOLD = 2'b01,
        SIL_MODE_AUTO_HOLD = 2'b10,
        SIL_MODE_AUTO = 2'b11
    } sil_mode_e;

endpackage

/* File: design/sil_sticky.sv */
`timescale 1ns/1ps
module sil_sticky
    import sil_pkg::*;
(
    input wire logic clk_i, // Register clock
    input wire logic reset_i, // Async reset, active high
    input wire logic ce_i, // Clock enable
    input wire sil_event_t cond_i, // Fault conditions, level
    input wire sil_event_t clr_i, // Write-1 clear strobes
    output sil_event_t lat_o // Latched flags
);

    sil_event_t next_lat;

    // Set beats clear so a persisting fault re-arms at once
    assign next_lat = cond_i | (lat_o & ~clr_i);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lat_o <= '0;
        end else if (ce_i) begin
            lat_o <= next_lat;
        end
    end

    sticky_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |cond_i |=> (lat_o & $past(cond_i)) == $past(cond_i))
        else $error("latched flag missed its condition");

    clear_persist_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |(clr_i & cond_i) |=> |(lat_o & $past(clr_i & cond_i)))
        else $error("clear won over a live condition");

endmodule

/* File: design/sil_selfclr.sv */
`timescale 1ns/1ps
module sil_selfclr
    import sil_pkg::*;
#(
    parameter logic [7:0] LEN = 8'h01
) (
    input wire logic clk_i, // Register clock
    input wire logic reset_i, // Async reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic start_i, // Write of 1 to the bit
    output logic busy_o // High for LEN cycles
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;

    // A restart while busy stretches the action
    assign next_cnt = start_i ? LEN
                    : (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    assign busy_o = (cnt != 8'h00);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= 8'h00;
        end else if (ce_i) begin
            cnt <= next_cnt;
        end
    end

    self_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && start_i && LEN == 8'h01 |=> busy_o ##1 (!busy_o || !ce_i
        || $past(start_i)))
        else $error("self-clearing bit did not clear");

endmodule

/* File: design/sil_ctrl.sv */
`timescale 1ns/1ps
`include "sil_map.svh"

module sil_ctrl
    import sil_pkg::*;
(
    input wire logic clk_i, // Register clock, 25 MHz
    input wire logic reset_i, // Power-on reset, async, active high
    input wire logic ce_i, // Clock enable, freezes all state
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    input wire logic [6:0] reg_addr_i, // Register address
    input wire logic [7:0] reg_wdata_i, // Write data
    output sil_byte_t reg_rdata_o, // Read data, one cycle after strobe
    input wire logic clk0_active_i, // Input 0 active
    input wire logic clk1_active_i, // Input 1 active
    input wire logic vcxo_locked_i, // VCXO-PLL locked
    input wire logic synth_locked_i, // Synthesizer PLL locked
    input wire logic holdover_i, // Device in holdover
    input wire logic vco_cal_done_i, // VCO calibration completed
    input wire logic [1:0] input_sel_i, // Selected input
    input wire logic [1:0] input_mode_i, // Input selection mode
    input wire logic ext_sysref_in_i, // External sysref trigger
    output logic irq_out_n_o, // Interrupt, active low
    output logic lock_o, // Combined lock
    output logic vcxo_ctrl_force_o, // Hold VCXO voltage at mid-supply
    output logic vcxo_pll_bypass_o, // VCXO-PLL bypass
    output logic vcxo_buf_en_o, // VCXO buffer output enable
    output sil_byte_t clk_out_en_o, // Clock output enables
    output sil_byte_t sysref_out_en_o, // Sysref output enables
    output logic divider_init_o, // Divider init running
    output logic outputs_low_o, // Force clock/sysref outputs low
    output logic pll_rearm_o, // Pll_rearm pulse
    output logic vco_calibrate_o, // Calibration pulse
    output logic sysref_start_o, // Sysref sequence start pulse
    output logic sysref_run_mode_o, // 1 continuous, 0 counted
    output sil_byte_t sysref_pulse_count_o // Pulse count for sequence
);

    localparam logic [7:0] INIT_LEN = 8'(`SIL_INIT_CYCLES);

    // Reference validity per input selection mode
    function automatic logic ref_ok(input logic [1:0] mode,
                                    input logic [1:0] sel,
                                    input logic c0,
                                    input logic c1,
                                    input logic hold);
        logic any_in;
        logic sel_in;
        any_in = c0 | c1;
        sel_in = (sel == 2'b00) ? c0 : (sel == 2'b01) ? c1 : 1'b0;
        case (mode)
            SIL_MODE_MANUAL: ref_ok = sel_in;
            SIL_MODE_SHORT_HOLD: ref_ok = sel_in;
            SIL_MODE_AUTO_HOLD: ref_ok = any_in & ~hold;
            SIL_MODE_AUTO: ref_ok = any_in;
            default: ref_ok = 1'b0;
        endcase
    endfunction

    function automatic logic hit(input logic [6:0] addr,
                                 input logic [6:0] ofs);
        hit = (addr == ofs);
    endfunction

    sil_byte_t ctrl;
    sil_event_t irq_en;
    logic [1:0] sysref_cfg;
    sil_byte_t sysref_cnt;
    sil_event_t latched;
    sil_rel_e rel_state;
    sil_rel_e next_rel_state;
    logic ext_prev;

    // Writes at or above the forbidden boundary are dropped
    wire wr_ok = reg_wr_i && (reg_addr_i < `SIL_OFS_FORBIDDEN);
    wire wr_ctrl = wr_ok && hit(reg_addr_i, `SIL_OFS_CTRL);
    wire wr_lat = wr_ok && hit(reg_addr_i, `SIL_OFS_LATCHED);
    wire wr_ien = wr_ok && hit(reg_addr_i, `SIL_OFS_IRQ_EN);
    wire wr_oe1 = wr_ok && hit(reg_addr_i, `SIL_OFS_OUT_EN_1);
    wire wr_oe2 = wr_ok && hit(reg_addr_i, `SIL_OFS_OUT_EN_2);
    wire wr_scfg = wr_ok && hit(reg_addr_i, `SIL_OFS_SYSREF_CFG);
    wire wr_scnt = wr_ok && hit(reg_addr_i, `SIL_OFS_SYSREF_CNT);

    wire init_go = wr_ctrl && reg_wdata_i[`SIL_CTRL_DIV_INIT];
    wire rearm_go = wr_ctrl && reg_wdata_i[`SIL_CTRL_REARM];
    wire cal_go = wr_ctrl && reg_wdata_i[`SIL_CTRL_CAL];
    wire rel_go = wr_ctrl && reg_wdata_i[`SIL_CTRL_RELEASE];

    wire ref_valid = ref_ok(input_mode_i, input_sel_i, clk0_active_i,
                            clk1_active_i, holdover_i);

    // Momentary view: 1 means good, as seen at this instant
    wire [7:0] mom_stat = {1'b0, vco_cal_done_i, ref_valid, ~holdover_i,
                           synth_locked_i, vcxo_locked_i, clk1_active_i,
                           clk0_active_i};
    wire [7:0] mom_sel = {6'h00, input_sel_i};

    // Latched flags hold faults, so 1 means the fault was seen
    wire [5:0] fault = {~ref_valid, holdover_i, ~synth_locked_i,
                        ~vcxo_locked_i, ~clk1_active_i, ~clk0_active_i};
    wire [5:0] lat_clr = wr_lat ? reg_wdata_i[5:0] : 6'h00;

    sil_sticky u_sticky (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cond_i(fault),
        .clr_i(lat_clr),
        .lat_o(latched)
    );

    sil_selfclr #(.LEN(INIT_LEN)) u_init (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .start_i(init_go),
        .busy_o(divider_init_o)
    );

    sil_selfclr #(.LEN(8'h01)) u_rearm (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .start_i(rearm_go),
        .busy_o(pll_rearm_o)
    );

    sil_selfclr #(.LEN(8'h01)) u_cal (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .start_i(cal_go),
        .busy_o(vco_calibrate_o)
    );

    assign outputs_low_o = divider_init_o;

    // Interrupt and lock, registered for clean pins
    wire irq_any = |(latched & irq_en);
    wire vcxo_ignored = ctrl[`SIL_CTRL_LOL_MASK]
                      | ctrl[`SIL_CTRL_BYPASS];
    wire next_lock = ~latched[`SIL_EV_SYNTH]
                   & (vcxo_ignored | ~latched[`SIL_EV_VCXO]);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_out_n_o <= 1'b1;
            lock_o <= 1'b0;
        end else if (ce_i) begin
            irq_out_n_o <= ~irq_any;
            lock_o <= next_lock;
        end
    end

    // Persistent control bits; self-clearing ones are not stored
    wire [7:0] ctrl_keep = (8'h01 << `SIL_CTRL_FORCE)
                         | (8'h01 << `SIL_CTRL_BYPASS)
                         | (8'h01 << `SIL_CTRL_LOL_MASK);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl <= `SIL_RST_CTRL;
            irq_en <= `SIL_RST_IRQ_EN;
            clk_out_en_o <= `SIL_RST_OUT_EN;
            sysref_out_en_o <= `SIL_RST_OUT_EN;
            sysref_cfg <= `SIL_RST_SYSREF_CFG;
            sysref_cnt <= `SIL_RST_SYSREF_CNT;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata_i & ctrl_keep;
            end
            if (wr_ien) begin
                irq_en <= reg_wdata_i[5:0];
            end
            if (wr_oe1) begin
                clk_out_en_o <= reg_wdata_i;
            end
            if (wr_oe2) begin
                sysref_out_en_o <= reg_wdata_i;
            end
            if (wr_scfg) begin
                sysref_cfg <= reg_wdata_i[1:0];
            end
            if (wr_scnt) begin
                sysref_cnt <= reg_wdata_i;
            end
        end
    end

    assign vcxo_ctrl_force_o = ctrl[`SIL_CTRL_FORCE];
    assign vcxo_pll_bypass_o = ctrl[`SIL_CTRL_BYPASS];
    assign vcxo_buf_en_o = `SIL_RST_VCXO_BUF;

    // Sysref release sequencing
    wire ext_rise = ext_sysref_in_i & ~ext_prev;
    wire fire_now = (rel_state == SIL_REL_FIRE && !divider_init_o)
                  || (rel_state == SIL_REL_WAIT_EDGE && ext_rise);

    always_comb begin
        next_rel_state = rel_state;
        case (rel_state)
            SIL_REL_IDLE: begin
                if (rel_go) begin
                    next_rel_state = sysref_cfg[`SIL_SRC_SEL]
                                   ? SIL_REL_WAIT_EDGE : SIL_REL_FIRE;
                end
            end
            SIL_REL_WAIT_EDGE: begin
                if (ext_rise) begin
                    next_rel_state = SIL_REL_IDLE;
                end
            end
            SIL_REL_FIRE: begin
                // Pulses wait for dividers to finish syncing
                if (!divider_init_o) begin
                    next_rel_state = SIL_REL_IDLE;
                end
            end
            default: next_rel_state = SIL_REL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rel_state <= SIL_REL_IDLE;
            ext_prev <= 1'b0;
            sysref_start_o <= 1'b0;
            sysref_run_mode_o <= 1'b0;
            sysref_pulse_count_o <= `SIL_RST_SYSREF_CNT;
        end else if (ce_i) begin
            rel_state <= next_rel_state;
            ext_prev <= ext_sysref_in_i;
            sysref_start_o <= fire_now;
            if (fire_now) begin
                sysref_run_mode_o <= sysref_cfg[`SIL_RUN_MODE];
                sysref_pulse_count_o <= sysref_cnt;
            end
        end
    end

    // Readback; self-clearing bits show activity in progress
    wire [7:0] ctrl_view = ctrl
        | {4'h0, rel_state != SIL_REL_IDLE, vco_calibrate_o, pll_rearm_o,
           divider_init_o};
    wire [7:0] rd_mux =
        hit(reg_addr_i, `SIL_OFS_MOM_SEL) ? mom_sel :
        hit(reg_addr_i, `SIL_OFS_MOM_STAT) ? mom_stat :
        hit(reg_addr_i, `SIL_OFS_LATCHED) ? {2'b00, latched} :
        hit(reg_addr_i, `SIL_OFS_IRQ_EN) ? {2'b00, irq_en} :
        hit(reg_addr_i, `SIL_OFS_CTRL) ? ctrl_view :
        hit(reg_addr_i, `SIL_OFS_OUT_EN_1) ? clk_out_en_o :
        hit(reg_addr_i, `SIL_OFS_SYSREF_CFG) ? {6'h00, sysref_cfg} :
        hit(reg_addr_i, `SIL_OFS_OUT_EN_2) ? sysref_out_en_o :
        hit(reg_addr_i, `SIL_OFS_SYSREF_CNT) ? sysref_cnt : 8'h00;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // Checks

    sequence init_hold_s;
        outputs_low_o [*8];
    endsequence

    sequence release_int_s;
        ce_i && rel_go && rel_state == SIL_REL_IDLE
        && !sysref_cfg[`SIL_SRC_SEL] && !divider_init_o && !init_go;
    endsequence

    mom_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && reg_rd_i && reg_addr_i == `SIL_OFS_MOM_STAT
        |=> reg_rdata_o == $past(mom_stat))
        else $error("momentary read not live");

    irq_assert_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && |(latched & irq_en) |=> !irq_out_n_o)
        else $error("enabled flag did not assert interrupt");

    irq_mask_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && irq_en == 6'h00 |=> irq_out_n_o)
        else $error("interrupt with all enables off");

    lock_both_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && latched[`SIL_EV_SYNTH] |=> !lock_o)
        else $error("lock high with synth unlock");

    lock_vcxo_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && !latched[`SIL_EV_SYNTH] && latched[`SIL_EV_VCXO]
        |=> lock_o == $past(vcxo_ignored))
        else $error("vcxo unlock handling wrong");

    ref_status_a: assert property (@(posedge clk_i) disable iff (reset_i)
        input_mode_i == SIL_MODE_AUTO && !clk0_active_i && !clk1_active_i
        |-> !mom_stat[5])
        else $error("reference valid with no input");

    force_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(vcxo_ctrl_force_o) |-> $past(wr_ctrl && ce_i))
        else $error("force dropped without a write");

    out_default_a: assert property (@(posedge clk_i)
        $fell(reset_i) |-> clk_out_en_o == 8'h00
        && sysref_out_en_o == 8'h00 && vcxo_buf_en_o && vcxo_ctrl_force_o)
        else $error("wrong reset defaults");

    init_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && init_go |=> init_hold_s)
        else $error("outputs not held low in init");

    rel_int_a: assert property (@(posedge clk_i) disable iff (reset_i)
        release_int_s |=> ##1 sysref_start_o ##1 rel_state == SIL_REL_IDLE)
        else $error("internal release did not fire");

    rel_ext_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && rel_state == SIL_REL_WAIT_EDGE && ext_rise
        |=> sysref_start_o && rel_state == SIL_REL_IDLE)
        else $error("external edge did not fire");

endmodule

/* File: verification/sil_host_model.sv */
`timescale 1ns/1ps
module sil_host_model (
    input wire logic clk_i, // Register clock
    input wire logic [7:0] rdata_i, // Read data from the device
    output logic wr_o, // Write strobe
    output logic rd_o, // Read strobe
    output logic [6:0] addr_o, // Register address
    output logic [7:0] wdata_o // Write data
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 7'h00;
        wdata_o = 8'h00;
    end

    // Each call below 7'h78 is its own one-byte access, never merged with another; calls at or above it make no access
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a >= 7'h78) begin
            return;
        end
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // Stale data would hide a late capture
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule

/* File: verification/sil_ctrl_tb.sv */
`timescale 1ns/1ps
`include "sil_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value at %0t line %0d got %h exp %h", \
    $time, `__LINE__, g, e); end end
module sil_ctrl_tb;
    import sil_pkg::*;
    logic clk_i, reset_i, hold, cal, ext, wr, rd, irq_n, lock, force_v;
    logic byp, buf_en, div_init, out_low, rearm, vcal, sstart, rmode, ce;
    logic [3:0] st;
    logic [1:0] sel, mode;
    logic [6:0] addr;
    logic [7:0] wdata;
    sil_byte_t rdata, clk_en, sr_en, pcnt;
    int n_mismatch = 0, num_checks = 0;
    int n_init = 0, n_low = 0, n_rearm = 0, n_cal = 0, n_start = 0;

    sil_host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    sil_ctrl uut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .clk0_active_i(st[0]),
        .clk1_active_i(st[1]), .vcxo_locked_i(st[2]),
        .synth_locked_i(st[3]), .holdover_i(hold), .vco_cal_done_i(cal),
        .input_sel_i(sel), .input_mode_i(mode), .ext_sysref_in_i(ext),
        .irq_out_n_o(irq_n), .lock_o(lock), .vcxo_ctrl_force_o(force_v),
        .vcxo_pll_bypass_o(byp), .vcxo_buf_en_o(buf_en),
        .clk_out_en_o(clk_en), .sysref_out_en_o(sr_en),
        .divider_init_o(div_init), .outputs_low_o(out_low),
        .pll_rearm_o(rearm), .vco_calibrate_o(vcal),
        .sysref_start_o(sstart), .sysref_run_mode_o(rmode),
        .sysref_pulse_count_o(pcnt));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        n_init += (div_init === 1'b1);
        n_low += (out_low === 1'b1);
        n_rearm += (rearm === 1'b1);
        n_cal += (vcal === 1'b1);
        n_start += (sstart === 1'b1);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask

    // Drops the masked conditions for one cycle
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_i);
        st <= st & ~m;
        @(posedge clk_i);
        st <= st | m;
        cyc(3);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] tbl [7];
        logic [7:0] d;
        int b;
        // exp, hold, mode, sel, clk0, clk1
        tbl = '{8'h01, 8'h85, 8'h16, 8'h30, 8'hB1, 8'hA2, 8'h62};
        reset_i = 1'b1;
        ce = 1'b1;
        st = 4'hF;
        hold = 1'b0;
        cal = 1'b1;
        ext = 1'b0;
        sel = 2'h0;
        mode = 2'h0;
        cyc(10);
        `CHK({irq_n, lock, force_v, buf_en}, 4'hB)
        `CHK({clk_en, sr_en}, 16'h0000)
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(`SIL_OFS_CTRL, 8'h10);
        rd_chk(`SIL_OFS_IRQ_EN, 8'h00);
        rd_chk(`SIL_OFS_OUT_EN_1, 8'h00);
        rd_chk(`SIL_OFS_OUT_EN_2, 8'h00);
        rd_chk(`SIL_OFS_SYSREF_CNT, 8'h01);
        rd_chk(`SIL_OFS_FORBIDDEN, 8'h00);
        rd_chk(`SIL_OFS_MOM_STAT, 8'h7F);
        // Covers every input mode, holdover included
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_i);
            {hold, mode, sel, st[0], st[1]} <= tbl[i][6:0];
            host.rd(`SIL_OFS_MOM_STAT, d);
            `CHK(d[5], tbl[i][7])
            `CHK(d[4], ~tbl[i][6])
        end
        @(posedge clk_i);
        {hold, mode, sel, st} <= 9'h00F;
        b = n_init;
        host.wr(`SIL_OFS_CTRL, 8'h11);
        cyc(30);
        `CHK(n_init - b, `SIL_INIT_CYCLES)
        `CHK(n_low - b, `SIL_INIT_CYCLES)
        rd_chk(`SIL_OFS_CTRL, 8'h10);
        b = n_rearm;
        host.wr(`SIL_OFS_CTRL, 8'h16);
        cyc(5);
        `CHK(n_rearm - b, 1)
        `CHK(n_cal - b, 1)
        `CHK(force_v, 1'b1)
        rd_chk(`SIL_OFS_CTRL, 8'h10);
        host.wr(`SIL_OFS_CTRL, 8'h00);
        host.wr(`SIL_OFS_LATCHED, 8'h3F);
        cyc(3);
        `CHK(force_v, 1'b0)
        `CHK(lock, 1'b1)
        rd_chk(`SIL_OFS_LATCHED, 8'h00);
        pulse(4'h2);
        rd_chk(`SIL_OFS_LATCHED, 8'h02);
        @(posedge clk_i);
        st[1] <= 1'b0;
        host.wr(`SIL_OFS_LATCHED, 8'h02);
        rd_chk(`SIL_OFS_LATCHED, 8'h02);
        `CHK(irq_n, 1'b1)
        host.wr(`SIL_OFS_IRQ_EN, 8'h02);
        cyc(3);
        `CHK(irq_n, 1'b0)
        host.wr(`SIL_OFS_IRQ_EN, 8'h01);
        cyc(3);
        `CHK(irq_n, 1'b1)
        host.wr(`SIL_OFS_IRQ_EN, 8'h02);
        @(posedge clk_i);
        st[1] <= 1'b1;
        host.wr(`SIL_OFS_LATCHED, 8'h02);
        cyc(3);
        `CHK(irq_n, 1'b1)
        pulse(4'h4);
        `CHK(lock, 1'b0)
        host.wr(`SIL_OFS_CTRL, 8'h40);
        cyc(3);
        `CHK(lock, 1'b1)
        host.wr(`SIL_OFS_CTRL, 8'h20);
        cyc(3);
        `CHK({lock, byp}, 2'h3)
        host.wr(`SIL_OFS_CTRL, 8'h00);
        cyc(3);
        `CHK(lock, 1'b0)
        host.wr(`SIL_OFS_LATCHED, 8'h04);
        cyc(3);
        `CHK(lock, 1'b1)
        host.wr(`SIL_OFS_CTRL, 8'h40);
        pulse(4'h8);
        `CHK(lock, 1'b0)
        host.wr(`SIL_OFS_LATCHED, 8'h08);
        host.wr(`SIL_OFS_CTRL, 8'h00);
        host.wr(`SIL_OFS_OUT_EN_1, 8'hA5);
        host.wr(`SIL_OFS_OUT_EN_2, 8'h3C);
        cyc(2);
        `CHK({clk_en, sr_en}, 16'hA53C)
        // A write while the clock enable is low must leave no trace
        @(posedge clk_i);
        ce <= 1'b0;
        host.wr(`SIL_OFS_OUT_EN_1, 8'hFF);
        ce <= 1'b1;
        rd_chk(`SIL_OFS_OUT_EN_1, 8'hA5);
        host.wr(`SIL_OFS_SYSREF_CNT, 8'h05);
        host.wr(`SIL_OFS_SYSREF_CFG, 8'h02);
        b = n_start;
        for (int i = 1; i <= 2; i++) begin
            host.wr(`SIL_OFS_CTRL, 8'h08);
            cyc(8);
            `CHK(n_start - b, i)
        end
        `CHK({rmode, pcnt}, 9'h105)
        host.wr(`SIL_OFS_SYSREF_CFG, 8'h01);
        host.wr(`SIL_OFS_CTRL, 8'h08);
        cyc(6);
        `CHK(n_start - b, 2)
        @(posedge clk_i);
        ext <= 1'b1;
        cyc(4);
        `CHK(n_start - b, 3)
        `CHK(rmode, 1'b0)
        tally_and_finish();
    end
endmodule
